// ---- rtl/sio_core.sv ----
// Servo drive I/O conditioning: commutation choice, input polarity, direction blocks,
// pole and line-count decode, monitor DAC routing. APB slave, one clock.
// Assumes pins arrive asynchronous; loop values arrive on sys_clk.
//
// Operation
// R1: Switch-selected mode picks six-step or serial feedback from setup switch.
// R2: Serial mode always uses serial feedback, ignoring switch.
// R3: Six-step mode always uses hall commutation, ignoring switch.
// R4: Brush mode forces six-step with halls U,V,W = 1,1,0.
// R5: Signed offset within +/-180 degrees added to commutation angle; default zero.
// R6: Host must program offset zero whenever six-step is used.
// R7: Enable input inverted when its polarity bit is one.
// R8: Clockwise block input inverted when its polarity bit is one.
// R9: Counter-clockwise block input inverted when its polarity bit is one.
// R10: General input one inverted when its polarity bit is one.
// R11: Each monitor DAC routes one of eight variables; second scales command in torque. Code does not scale: at select one it takes slot eight's source.
// R12: Zero selected signal gives mid-scale DAC code.
// R13: Monitor values wrap around, never saturate.
// R14: Pole field n means 2n poles.
// R15: Pole field zero disables electronic commutation.
// R16: Line-count code used only at rotary switch position zero.
// R17: Code maps to fixed line table; four quadrature counts per line.
// R18: Enabled active ccw block clamps command to zero or positive.
// R19: Enabled active cw block clamps command to zero or negative.
// R20: Both blocks enabled and active force command to exactly zero.
// R21: Option-card feedback disables base serial and hall faults, zeroes position.
// R22: Configuration held in host registers, effective next cycle.
`include "sio_defs.svh"

module sio_core (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic digital_input_1,
	input wire logic digital_input_2,
	input wire logic digital_input_3,
	input wire logic digital_input_4,
	input wire logic switch_selected_commutation,
	input wire logic [3:0] emulation_rotary_switch,
	input wire logic hall_phase_u,
	input wire logic hall_phase_v,
	input wire logic hall_phase_w,
	input wire logic [15:0] serial_position_in,
	input wire logic signed [15:0] electrical_angle_in,
	input wire logic signed [15:0] loop_command_in,
	input wire logic [8*16-1:0] monitor1_sources,
	input wire logic [8*16-1:0] monitor2_sources,
	output logic use_serial_feedback,
	output logic commutation_enabled,
	output logic [2:0] hall_to_commutation,
	output logic signed [15:0] commutation_angle,
	output logic [15:0] serial_position_out,
	output logic base_feedback_faults_enabled,
	output logic [5:0] motor_poles,
	output logic [15:0] emulated_line_count,
	output logic [17:0] quadrature_counts_per_rev,
	output logic drive_enable,
	output logic general_input_one,
	output logic signed [15:0] limited_command,
	output logic [11:0] monitor_dac_one,
	output logic [11:0] monitor_dac_two
);
	import sio_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		logic [31:0] cfg;
		logic signed [15:0] offset;
		logic [7:0] mon_sel;
		logic [3:0] pin_meta;
		logic [3:0] pin_sync;
		logic sw_meta;
		logic sw_sync;
		logic [3:0] emu_meta;
		logic [3:0] emu_sync;
		logic [2:0] hall_meta;
		logic [2:0] hall_sync;
		logic [31:0] rdata;
		logic use_serial;
		logic comm_en;
		logic [2:0] halls;
		logic signed [15:0] angle;
		logic [15:0] spos;
		logic fb_faults;
		logic [5:0] poles;
		logic [15:0] lines;
		logic enable_in;
		logic gp_in;
		logic signed [15:0] cmd;
		logic [11:0] dac1;
		logic [11:0] dac2;
	} sio_state_type;

	sio_state_type state_reg;
	sio_state_type state_next;

	// ==========================================================
	// Helpers
	function automatic logic [15:0] line_lookup(input logic [3:0] code);
		case (code)
			4'h0: line_lookup = 16'd500;
			4'h1: line_lookup = 16'd512;
			4'h2: line_lookup = 16'd1000;
			4'h3: line_lookup = 16'd1024;
			4'h4: line_lookup = 16'd2000;
			4'h5: line_lookup = 16'd2048;
			4'h6: line_lookup = 16'd4096;
			4'h7: line_lookup = 16'd5000;
			4'h8: line_lookup = 16'd8192;
			4'h9: line_lookup = 16'd10000;
			4'hA: line_lookup = 16'd125;
			4'hB: line_lookup = 16'd128;
			4'hC: line_lookup = 16'd16384;
			4'hD: line_lookup = 16'd20000;
			4'hE: line_lookup = 16'd32768;
			default: line_lookup = 16'd2500;
		endcase
	endfunction

	// Top twelve bits, sign flipped: zero lands mid-scale, overflow wraps
	function automatic logic [11:0] dac_code(input logic [15:0] v);
		dac_code = v[15:4] ^ `SIO_DAC_MID;
	endfunction

	// Fixed line counts for switch positions other than zero
	function automatic logic [15:0] switch_lines(input logic [3:0] pos);
		switch_lines = line_lookup(pos);
	endfunction

	// ==========================================================
	// Next state
	logic apb_access;
	logic apb_write;
	logic [3:0] pins_cond;
	logic ccw_block;
	logic cw_block;
	logic fb_option;
	sio_comm_type comm_mode;
	logic [15:0] mon2_src;

	assign apb_access = psel && penable;
	assign apb_write = apb_access && pwrite;

	always_comb begin
		state_next = state_reg;
		// Synchronisers; stage one only feeds stage two
		state_next.pin_meta = {digital_input_4, digital_input_3, digital_input_2, digital_input_1};
		state_next.pin_sync = state_reg.pin_meta;
		state_next.sw_meta = switch_selected_commutation;
		state_next.sw_sync = state_reg.sw_meta;
		state_next.emu_meta = emulation_rotary_switch;
		state_next.emu_sync = state_reg.emu_meta;
		state_next.hall_meta = {hall_phase_w, hall_phase_v, hall_phase_u};
		state_next.hall_sync = state_reg.hall_meta;

		// Host writes, effective next cycle
		if (apb_write) begin
			case (paddr)
				`SIO_CFG_OFS: state_next.cfg = pwdata; // R22
				`SIO_OFFSET_OFS: state_next.offset = pwdata[15:0]; // R5
				`SIO_MON_OFS: state_next.mon_sel = pwdata[7:0];
				default: state_next.cfg = state_reg.cfg;
			endcase
		end

		// Polarity conditioning, bit set inverts
		pins_cond = state_reg.pin_sync ^ state_reg.cfg[`SIO_CFG_INV_LSB +: 4]; // R7 R8 R9 R10
		state_next.enable_in = pins_cond[0]; // R7
		state_next.gp_in = pins_cond[3]; // R10
		cw_block = state_reg.cfg[`SIO_CFG_CWEN_BIT] && pins_cond[1]; // R8 R19
		ccw_block = state_reg.cfg[`SIO_CFG_CCWEN_BIT] && pins_cond[2]; // R9 R18

		// Direction blocking
		if (cw_block && ccw_block)
			state_next.cmd = 16'sh0000; // R20
		else if (ccw_block && loop_command_in < 0)
			state_next.cmd = 16'sh0000; // R18
		else if (cw_block && loop_command_in > 0)
			state_next.cmd = 16'sh0000; // R19
		else
			state_next.cmd = loop_command_in;

		// Commutation source
		comm_mode = sio_comm_type'(state_reg.cfg[`SIO_CFG_COMM_LSB +: 2]);
		fb_option = state_reg.cfg[`SIO_CFG_FEEDBACK_SOURCE_SELECT_BIT];
		state_next.halls = state_reg.hall_sync;
		case (comm_mode)
			SIO_COMM_SWITCH: state_next.use_serial = state_reg.sw_sync; // R1
			SIO_COMM_SERIAL: state_next.use_serial = 1'b1; // R2
			SIO_COMM_SIX_STEP: state_next.use_serial = 1'b0; // R3
			SIO_COMM_BRUSH: begin
				state_next.use_serial = 1'b0; // R4
				state_next.halls = `SIO_BRUSH_HALLS; // R4
			end
			default: state_next.use_serial = 1'b0;
		endcase
		// Offset assumed zero by host in six-step; added unconditionally
		state_next.angle = 16'(electrical_angle_in + state_reg.offset); // R5
		state_next.fb_faults = !fb_option; // R21
		state_next.spos = fb_option ? 16'h0000 : serial_position_in; // R21

		// Poles and line count
		state_next.poles = {state_reg.cfg[`SIO_CFG_POLE_LSB +: 5], 1'b0}; // R14
		state_next.comm_en = state_reg.cfg[`SIO_CFG_POLE_LSB +: 5] != 5'h00; // R15
		if (state_reg.emu_sync == 4'h0)
			state_next.lines = line_lookup(state_reg.cfg[`SIO_CFG_LINE_LSB +: 4]); // R16 R17
		else
			state_next.lines = switch_lines(state_reg.emu_sync); // R16

		// Monitor DACs; torque mode takes the command from slot eight's source
		mon2_src = monitor2_sources[state_reg.mon_sel[`SIO_MON2_LSB +: 3]*16 +: 16];
		if (state_reg.cfg[`SIO_CFG_TORQUE_BIT] && state_reg.mon_sel[`SIO_MON2_LSB +: 3] == 3'h1)
			mon2_src = monitor2_sources[7*16 +: 16]; // R11
		state_next.dac1 = dac_code(
			monitor1_sources[state_reg.mon_sel[`SIO_MON1_LSB +: 3]*16 +: 16]); // R11 R12 R13
		state_next.dac2 = dac_code(mon2_src); // R12 R13

		// Read data, registered for the next access
		case (paddr)
			`SIO_CFG_OFS: state_next.rdata = state_reg.cfg;
			`SIO_OFFSET_OFS: state_next.rdata = {{16{state_reg.offset[15]}}, state_reg.offset};
			`SIO_CMD_OFS: state_next.rdata = {16'h0000, state_reg.cmd};
			`SIO_MON_OFS: state_next.rdata = {24'h000000, state_reg.mon_sel};
			`SIO_STAT_OFS: state_next.rdata = {24'h000000, state_reg.use_serial,
				state_reg.comm_en, state_reg.pin_sync ^ state_reg.cfg[`SIO_CFG_INV_LSB +: 4],
				cw_block, ccw_block};
			`SIO_LIMIT_OFS: state_next.rdata = {26'h0000000, state_reg.poles};
			`SIO_ENC_OFS: state_next.rdata = {16'h0000, state_reg.lines};
			default: state_next.rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_reg <= '0;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	// ==========================================================
	// APB answer: zero wait states; cfg and offset read combinational, other registers from rdata registered in the setup cycle
	logic addr_ok;
	assign addr_ok = paddr <= `SIO_ENC_OFS && paddr[1:0] == 2'h0;
	assign pready = 1'b1;
	assign pslverr = apb_access && !addr_ok;
	always_comb begin
		case (paddr)
			`SIO_CFG_OFS: prdata = state_reg.cfg;
			`SIO_OFFSET_OFS: prdata = {{16{state_reg.offset[15]}}, state_reg.offset};
			default: prdata = state_reg.rdata;
		endcase
	end

	// ==========================================================
	// Outputs
	assign use_serial_feedback = state_reg.use_serial;
	assign commutation_enabled = state_reg.comm_en;
	assign hall_to_commutation = state_reg.halls;
	assign commutation_angle = state_reg.angle;
	assign serial_position_out = state_reg.spos;
	assign base_feedback_faults_enabled = state_reg.fb_faults;
	assign motor_poles = state_reg.poles;
	assign emulated_line_count = state_reg.lines;
	assign quadrature_counts_per_rev = {state_reg.lines, 2'b00}; // R17
	assign drive_enable = state_reg.enable_in;
	assign general_input_one = state_reg.gp_in;
	assign limited_command = state_reg.cmd;
	assign monitor_dac_one = state_reg.dac1;
	assign monitor_dac_two = state_reg.dac2;

	// ==========================================================
	// Checks
	property p_brush;
		@(posedge sys_clk) disable iff (reset)
		clk_en && state_reg.cfg[1:0] == 2'h2 |=> hall_to_commutation == 3'h3 && !use_serial_feedback;
	endproperty
	a_brush: assert property (p_brush) else $error("brush halls wrong"); // R4

	property p_serial;
		@(posedge sys_clk) disable iff (reset)
		clk_en && state_reg.cfg[1:0] == 2'h1 |=> use_serial_feedback;
	endproperty
	a_serial: assert property (p_serial) else $error("serial not chosen"); // R2

	property p_six;
		@(posedge sys_clk) disable iff (reset)
		clk_en && state_reg.cfg[1:0] == 2'h3 |=> !use_serial_feedback;
	endproperty
	a_six: assert property (p_six) else $error("six-step not chosen"); // R3

	property p_both;
		@(posedge sys_clk) disable iff (reset)
		clk_en && cw_block && ccw_block |=> limited_command == 16'sh0000;
	endproperty
	a_both: assert property (p_both) else $error("command not zeroed"); // R20

	property p_ccw;
		@(posedge sys_clk) disable iff (reset)
		clk_en && ccw_block |=> limited_command >= 0;
	endproperty
	a_ccw: assert property (p_ccw) else $error("ccw clamp failed"); // R18

	property p_cw;
		@(posedge sys_clk) disable iff (reset)
		clk_en && cw_block |=> limited_command <= 0;
	endproperty
	a_cw: assert property (p_cw) else $error("cw clamp failed"); // R19

	property p_poles;
		@(posedge sys_clk) disable iff (reset)
		clk_en |=> commutation_enabled == ($past(state_reg.cfg[`SIO_CFG_POLE_LSB +: 5]) != 5'h00);
	endproperty
	a_poles: assert property (p_poles) else $error("pole enable mismatch"); // R15

	property p_option;
		@(posedge sys_clk) disable iff (reset)
		clk_en && state_reg.cfg[`SIO_CFG_FEEDBACK_SOURCE_SELECT_BIT] |=> serial_position_out == 16'h0000
			&& !base_feedback_faults_enabled;
	endproperty
	a_option: assert property (p_option) else $error("option feedback not honoured"); // R21

	property p_enable;
		@(posedge sys_clk) disable iff (reset)
		clk_en |=> drive_enable
			== $past(state_reg.pin_sync[0] ^ state_reg.cfg[`SIO_CFG_INV_LSB]);
	endproperty
	a_enable: assert property (p_enable) else $error("enable polarity wrong"); // R7

	property p_general;
		@(posedge sys_clk) disable iff (reset)
		clk_en |=> general_input_one
			== $past(state_reg.pin_sync[3] ^ state_reg.cfg[`SIO_CFG_INV_LSB + 3]);
	endproperty
	a_general: assert property (p_general) else $error("general input polarity wrong"); // R10

	property p_switch;
		@(posedge sys_clk) disable iff (reset)
		clk_en && state_reg.cfg[1:0] == 2'h0 |=> use_serial_feedback == $past(state_reg.sw_sync);
	endproperty
	a_switch: assert property (p_switch) else $error("switch choice not followed"); // R1

	property p_pole_decode;
		@(posedge sys_clk) disable iff (reset)
		clk_en |=> motor_poles == {$past(state_reg.cfg[`SIO_CFG_POLE_LSB +: 5]), 1'b0};
	endproperty
	a_pole_decode: assert property (p_pole_decode) else $error("pole decode wrong"); // R14

	property p_hall_pass;
		@(posedge sys_clk) disable iff (reset)
		clk_en && state_reg.cfg[1:0] == 2'h3 |=> hall_to_commutation == $past(state_reg.hall_sync);
	endproperty
	a_hall_pass: assert property (p_hall_pass) else $error("hall inputs not used"); // R3

	property p_dac_mid;
		@(posedge sys_clk) disable iff (reset)
		clk_en && monitor1_sources[state_reg.mon_sel[`SIO_MON1_LSB +: 3] * 16 +: 16] == 16'h0000
			|=> monitor_dac_one == `SIO_DAC_MID;
	endproperty
	a_dac_mid: assert property (p_dac_mid) else $error("zero not mid-scale"); // R12

	property p_angle;
		@(posedge sys_clk) disable iff (reset)
		clk_en |=> commutation_angle
			== 16'($past(electrical_angle_in) + $past(state_reg.offset));
	endproperty
	a_angle: assert property (p_angle) else $error("angle offset wrong"); // R5
endmodule

// ---- rtl/sio_defs.svh ----
// Offsets, field positions, reset values and encodings of the servo I/O configuration block.
// Assumes a 32-bit APB register bus with one register per aligned word.
`ifndef SIO_DEFS_SVH
`define SIO_DEFS_SVH

// ==========================================================
// Register offsets
`define SIO_CFG_OFS 12'h000
`define SIO_OFFSET_OFS 12'h004
`define SIO_CMD_OFS 12'h008
`define SIO_MON_OFS 12'h00C
`define SIO_STAT_OFS 12'h010
`define SIO_LIMIT_OFS 12'h014
`define SIO_ENC_OFS 12'h018

// ==========================================================
// Fields of the configuration register
`define SIO_CFG_COMM_LSB 0
`define SIO_CFG_INV_LSB 2
`define SIO_CFG_POLE_LSB 8
`define SIO_CFG_LINE_LSB 16
`define SIO_CFG_CCWEN_BIT 20
`define SIO_CFG_CWEN_BIT 21
`define SIO_CFG_FEEDBACK_SOURCE_SELECT_BIT 22
`define SIO_CFG_TORQUE_BIT 23
`define SIO_CFG_RESET 32'h0000_0000

// ==========================================================
// Monitor select fields
`define SIO_MON1_LSB 0
`define SIO_MON2_LSB 4

// ==========================================================
// Hall substitute pattern for brush operation (w,v,u)
`define SIO_BRUSH_HALLS 3'h3
// Mid-scale DAC code
`define SIO_DAC_MID 12'h800

`endif

// ---- rtl/sio_pkg.sv ----
// Types of the servo I/O configuration block.
// Assumes sio_defs.svh supplies the numeric constants.
package sio_pkg;
	typedef enum logic [1:0] {
		SIO_COMM_SWITCH = 2'h0,
		SIO_COMM_SERIAL = 2'h1,
		SIO_COMM_SIX_STEP = 2'h3,
		SIO_COMM_BRUSH = 2'h2
	} sio_comm_type;
endpackage

// ---- tb/sio_ctrl_model.sv ----
// Motion controller model: drives enable, cw/ccw block and general input pins.
// Assumes the bench gives wanted levels; pins change only after a clock edge.
module sio_ctrl_model (
	input wire logic sys_clk,
	input wire logic [3:0] want,
	output logic digital_input_1,
	output logic digital_input_2,
	output logic digital_input_3,
	output logic digital_input_4
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {digital_input_4, digital_input_3, digital_input_2, digital_input_1} = 4'h0;
	// Levels change just after a rising edge, never on the sampling edge
	always @(posedge sys_clk) begin
		{digital_input_4, digital_input_3, digital_input_2, digital_input_1} <= want;
	end
endmodule

// ---- tb/servo_io_config_logic_tb_top.sv ----
// Self-checking bench of sio_core over APB with a controller model on the pins.
// Assumes sio_defs.svh is on the include path.
`include "sio_defs.svh"
module servo_io_config_logic_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, en = 1;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, e, d1, d2, d3, d4, sw = 0, hu = 0, hv = 0, hw = 0;
	logic [3:0] rot = 4'h0, want = 4'h0;
	logic [15:0] spos = 16'h0, ang = 16'h0, cmd = 16'h0, off;
	logic [127:0] m1 = '0, m2 = '0, mt;
	logic use_ser, com_en, fb_en, den, gp1;
	logic [2:0] hall;
	logic [15:0] cang, spo, lines, lim, dv[16];
	logic [5:0] poles;
	logic [17:0] quad;
	logic [11:0] dac1, dac2;
	int failures = 0, samples_checked = 0, k, s, b;
	always #5 sys_clk = ~sys_clk;
	sio_ctrl_model u_ctrl (.sys_clk(sys_clk), .want(want), .digital_input_1(d1),
		.digital_input_2(d2), .digital_input_3(d3), .digital_input_4(d4));
	sio_core u_dut (.sys_clk(sys_clk), .reset(reset), .clk_en(en), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .digital_input_1(d1), .digital_input_2(d2),
		.digital_input_3(d3), .digital_input_4(d4), .switch_selected_commutation(sw),
		.emulation_rotary_switch(rot), .hall_phase_u(hu), .hall_phase_v(hv), .hall_phase_w(hw),
		.serial_position_in(spos), .electrical_angle_in(ang), .loop_command_in(cmd),
		.monitor1_sources(m1), .monitor2_sources(m2), .use_serial_feedback(use_ser),
		.commutation_enabled(com_en), .hall_to_commutation(hall), .commutation_angle(cang),
		.serial_position_out(spo), .base_feedback_faults_enabled(fb_en), .motor_poles(poles),
		.emulated_line_count(lines), .quadrature_counts_per_rev(quad), .drive_enable(den),
		.general_input_one(gp1), .limited_command(lim), .monitor_dac_one(dac1),
		.monitor_dac_two(dac2));
	task close_out;
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", n, exp, seen);
		end
	endtask
	// Request held until pready is seen high at a rising edge; answer taken there
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		logic r;
		n = 0;
		@(posedge sys_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge sys_clk);
		penable <= 1;
		do begin
			@(posedge sys_clk);
			n++;
			r = pready;
			q = prdata;
			e = pslverr;
		end while (r !== 1'b1 && n < 20);
		psel <= 0;
		penable <= 0;
		if (n >= 20) begin
			failures++;
			close_out();
		end
	endtask
	function automatic logic [31:0] cfg(int md, int inv, int pl, int ln, int ccw, int cw, int fb);
		return {9'h0, fb[0], cw[0], ccw[0], ln[3:0], 3'h0, pl[4:0], 2'h0, inv[3:0], md[1:0]};
	endfunction
	function automatic logic [15:0] clamp(logic [15:0] c, logic cwa, logic ccwa);
		if ((cwa && ccwa) || (cwa && $signed(c) > 0) || (ccwa && $signed(c) < 0))
			return 16'h0;
		return c;
	endfunction
	function automatic logic [11:0] dcode(logic [15:0] v);
		return {~v[15], v[14:4]};
	endfunction
	task w(int n);
		repeat (n) @(posedge sys_clk);
	endtask
	initial begin
		dv = '{16'd500, 16'd512, 16'd1000, 16'd1024, 16'd2000, 16'd2048, 16'd4096, 16'd5000,
			16'd8192, 16'd10000, 16'd125, 16'd128, 16'd16384, 16'd20000, 16'd32768, 16'd2500};
		k = $urandom(21500);
		w(12);
		reset <= 0;
		w(3);
		apb(0, `SIO_CFG_OFS, 0);
		chk("cfg reset", q, `SIO_CFG_RESET);
		chk("dac mid", {20'h0, dac1}, `SIO_DAC_MID);
		apb(1, 12'h01C, 32'hFFFF_FFFF);
		apb(0, 12'h01C, 0);
		chk("unmapped", {q[30:0], e}, 32'h1);
		for (k = 0; k < 16; k++) begin
			apb(1, `SIO_CFG_OFS, cfg(0, 0, 1, k, 0, 0, 0));
			w(4);
			chk("lines", lines, dv[k]);
			chk("quad", quad, {dv[k], 2'h0});
		end
		rot <= 4'h5;
		w(5);
		chk("switch lines", lines, dv[5]);
		rot <= 4'h0;
		foreach (dv[i]) begin
			k = (i == 0) ? 0 : (i == 1) ? 31 : $urandom_range(31);
			apb(1, `SIO_CFG_OFS, cfg(3, 0, k, 0, 0, 0, 0));
			w(4);
			chk("poles", poles, 2 * k);
			chk("comm on", com_en, k != 0);
		end
		for (k = 0; k < 8; k++) begin
			sw <= k[0];
			{hw, hv, hu} <= $urandom;
			apb(1, `SIO_CFG_OFS, cfg(k / 2, 0, 1, 0, 0, 0, 0));
			w(5);
			chk("serial", use_ser, k / 2 == 1 || (k / 2 == 0 && k[0]));
			if (k / 2 == 2)
				chk("brush halls", hall, `SIO_BRUSH_HALLS);
			if (k / 2 == 3)
				chk("halls", hall, {hw, hv, hu});
		end
		// Leave six-step before a non-zero offset is written
		apb(1, `SIO_CFG_OFS, cfg(1, 0, 1, 0, 0, 0, 0));
		for (k = 0; k < 6; k++) begin
			off = $urandom;
			ang <= $urandom;
			apb(1, `SIO_OFFSET_OFS, {16'h0, off});
			w(4);
			chk("angle", cang, 16'(ang + off));
		end
		for (k = 0; k < 24; k++) begin
			b = (k < 2) ? 32'h30F : $urandom;
			want <= b[3:0];
			cmd <= (k == 1) ? 16'h8000 : $urandom;
			apb(1, `SIO_CFG_OFS, cfg(1, b[7:4], 1, 0, b[8] | k < 2, b[9] | k < 2, 0));
			w(6);
			chk("enable", den, b[0] ^ b[4]);
			chk("gp input", gp1, b[3] ^ b[7]);
			chk("limit", lim, clamp(cmd, (b[9] | k < 2) & (b[1] ^ b[5]),
				(b[8] | k < 2) & (b[2] ^ b[6])));
		end
		for (k = 0; k < 8; k++) begin
			s = $urandom_range(7);
			b = (k == 4) ? 1 : $urandom_range(7);
			mt = {$urandom, $urandom, $urandom, $urandom};
			mt[16 * s +: 16] = (k == 0) ? 16'h7FFF : 16'h8000;
			m1 <= mt;
			m2 <= {$urandom, $urandom, $urandom, $urandom};
			// Upper half of the loop runs in torque mode
			apb(1, `SIO_CFG_OFS, cfg(1, 0, 1, 0, 0, 0, 0)
				| ((32'h1 << `SIO_CFG_TORQUE_BIT) & {32{k >= 4}}));
			apb(1, `SIO_MON_OFS, {25'h0, b[2:0], 1'b0, s[2:0]});
			w(4);
			chk("dac one", dac1, (k == 0) ? 12'hFFF : 12'h000);
			chk("dac two", dac2, dcode(m2[16 * ((k >= 4 && b == 1) ? 7 : b) +: 16]));
		end
		spos <= $urandom;
		w(3);
		chk("fb on", {fb_en, spo}, {1'b1, spos});
		apb(1, `SIO_CFG_OFS, cfg(1, 0, 1, 0, 0, 0, 1));
		w(4);
		chk("fb off", {fb_en, spo}, 17'h0);
		// Clock enable low: the write is lost and outputs hold
		en <= 0;
		apb(1, `SIO_CFG_OFS, cfg(1, 0, 7, 0, 0, 0, 0));
		chk("frozen poles", poles, 6'h02);
		en <= 1;
		apb(0, `SIO_CFG_OFS, 0);
		chk("write lost", q, cfg(1, 0, 1, 0, 0, 0, 1));
		close_out();
	end
endmodule
